/* File: logic/port_e_bus_control_pin_mux.sv */
`timescale 1ns/10ps
// Summary of operation
// - Read/write pin pulled-up input until enabled
// - Low strobe pin driven only when enabled or its direction bit is set
// - Strobe pin doubles as low tag input
// - Bits 6,5 carry time-multiplexed queue tracking
// - Bus drive enable low during E high
// - Stretched access: enable only final quarter
// - Drive enable on out of reset, expanded
// - Drive enable gates external bus reads
// - Bit 7 may output inverted E clock
// - Calibration output is 50% slow clock
// - Drive enable overrides calibration output
// - Clearing calib_out_en disables calibration output
// - Clock generator test clocks on bit 6
// - Test output needs queue tracking off
// - Reset pin bidirectional, driven by watchdog
// - Bit 4 outputs the bus E clock in expanded mode
// - After reset clocks follow crystal rate
// - Low strobe is XNOR of A0, size
module port_e_bus_control_pin_mux (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic mode_expanded_pin,
  input wire logic mode_special_pin,
  input wire logic ext_access,
  input wire logic [1:0] ext_stretch,
  input wire logic core_read,
  input wire logic core_addr0,
  input wire logic byte_size_n,
  input wire logic [1:0] queue_move,
  input wire logic [1:0] queue_exec,
  input wire logic clockgen_test_out,
  input wire logic watchdog_timeout,
  input wire logic clock_monitor_fail,
  input wire logic [7:0] port_e_in,
  output logic [7:0] port_e_out,
  output logic [7:0] port_e_oe,
  output logic [7:0] port_e_pullup,
  output logic low_tag_input,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic pin_reset_n
);
  import pe_ctrl_pkg::*;

  logic [7:0] assign_r;
  logic [7:0] data_r;
  logic [7:0] dir_r;
  logic [7:0] slow_div_r;
  logic [7:0] slow_cnt_r;
  logic slow_divided_clock;
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  logic [1:0] mode_s1_r;
  logic [1:0] mode_s2_r;
  logic rst_s1_r;
  logic rst_s2_r;
  logic init_r;
  logic expanded_r;
  logic special_r;
  logic [1:0] quarter_r;
  logic [1:0] stretch_left_r;
  logic stretch_act_r;
  logic bus_e_clock;
  logic bus_drive_enable_n;
  logic [7:0] pe_out_nxt;
  logic [7:0] pe_oe_nxt;
  pe7_func_t pe7_func;
  logic rw_en;
  logic low_byte_strobe_n_en;
  logic qt_en;
  logic cgm_en;
  logic e_high;

  // Mode straps and pins come from outside the clock domain
  always_ff @(posedge clk) begin
    pin_s1_r <= port_e_in;
    pin_s2_r <= pin_s1_r;
    mode_s1_r <= {mode_special_pin, mode_expanded_pin};
    mode_s2_r <= mode_s1_r;
    rst_s1_r <= reset_pin_in;
    rst_s2_r <= rst_s1_r;
  end

  // Straps caught in the first cycle after reset release
  always_ff @(posedge clk) begin
    if (!nrst) begin
      init_r <= 1'b1;
      expanded_r <= 1'b0;
      special_r <= 1'b0;
    end else if (init_r) begin
      init_r <= 1'b0;
      expanded_r <= mode_s2_r[0];
      special_r <= mode_s2_r[1];
    end
  end

  // Register writes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      assign_r <= ASSIGN_RESET;
      data_r <= DATA_RESET;
      dir_r <= DIR_RESET;
      slow_div_r <= SLOW_DIV_RESET;
    end else begin
      if (init_r) begin
        assign_r[BIT_BUS_DRIVE_CTRL_OFF] <= ~mode_s2_r[0];
      end
      if (reg_wr) begin
        unique case (reg_addr)
          ADDR_ASSIGN: assign_r <= reg_wdata;
          ADDR_DATA: data_r <= reg_wdata;
          ADDR_DIR: dir_r <= reg_wdata;
          ADDR_SLOW_DIV: slow_div_r <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_ASSIGN: reg_rdata <= assign_r;
        ADDR_DATA: reg_rdata <= data_r;
        ADDR_DIR: reg_rdata <= dir_r;
        ADDR_SLOW_DIV: reg_rdata <= slow_div_r;
        ADDR_STATUS: reg_rdata <= {5'h00, special_r, expanded_r, rst_s2_r};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Slow divider: toggling keeps the duty at exactly half
  always_ff @(posedge clk) begin
    if (!nrst) begin
      slow_cnt_r <= 8'h00;
      slow_divided_clock <= 1'b0;
    end else if (slow_cnt_r >= slow_div_r) begin
      slow_cnt_r <= 8'h00;
      slow_divided_clock <= ~slow_divided_clock;
    end else begin
      slow_cnt_r <= slow_cnt_r + 8'h01;
    end
  end

  // E clock quarters; a stretch counts extra whole E cycles
  always_ff @(posedge clk) begin
    if (!nrst) begin
      quarter_r <= 2'h0;
      stretch_left_r <= 2'h0;
      stretch_act_r <= 1'b0;
    end else begin
      quarter_r <= quarter_r + 2'h1;
      if (quarter_r == Q_LAST) begin
        if (stretch_act_r && stretch_left_r != 2'h0) begin
          stretch_left_r <= stretch_left_r - 2'h1;
        end else if (ext_access && ext_stretch != 2'h0) begin
          stretch_act_r <= 1'b1;
          stretch_left_r <= ext_stretch;
        end else begin
          stretch_act_r <= 1'b0;
        end
      end
    end
  end

  assign e_high = quarter_r >= Q_HIGH_FIRST;
  assign bus_e_clock = e_high;

  // Stretched cycle opens the bus only in its last quarter
  always_comb begin
    if (stretch_act_r) begin
      bus_drive_enable_n = ~(quarter_r == Q_LAST &&
                             stretch_left_r == 2'h0);
    end else begin
      bus_drive_enable_n = ~e_high;
    end
  end

  assign rw_en = expanded_r && assign_r[BIT_READ_WRITE_FUNC_EN];
  assign low_byte_strobe_n_en = expanded_r && assign_r[BIT_LOW_STROBE_FUNC_EN];
  assign qt_en = expanded_r && assign_r[BIT_QUEUE_TRACK_OUT_EN];
  assign cgm_en = assign_r[BIT_CLOCKGEN_TEST_EN] &&
                  !assign_r[BIT_QUEUE_TRACK_OUT_EN];

  // Bit 7 priority: inverted E, drive enable, calibration, GPIO
  always_comb begin
    if (expanded_r && !assign_r[BIT_BUS_DRIVE_CTRL_OFF]) begin
      if (assign_r[BIT_INV_ECLOCK_SEL]) begin
        pe7_func = P7_INV_E;
      end else begin
        pe7_func = P7_DBE;
      end
    end else if (assign_r[BIT_CALIB_OUT_EN]) begin
      pe7_func = P7_CAL;
    end else begin
      pe7_func = P7_GPIO;
    end
  end

  always_comb begin
    pe_out_nxt = data_r;
    pe_oe_nxt = dir_r;
    unique case (pe7_func)
      P7_DBE: pe_out_nxt[PIN_DBE] = bus_drive_enable_n;
      P7_INV_E: pe_out_nxt[PIN_DBE] = ~bus_e_clock;
      P7_CAL: pe_out_nxt[PIN_DBE] = slow_divided_clock;
      default: pe_out_nxt[PIN_DBE] = data_r[PIN_DBE];
    endcase
    if (pe7_func != P7_GPIO) begin
      pe_oe_nxt[PIN_DBE] = 1'b1;
    end
    if (cgm_en) begin
      pe_out_nxt[PIN_QHI] = clockgen_test_out;
      pe_oe_nxt[PIN_QHI] = 1'b1;
    end else if (qt_en) begin
      pe_out_nxt[PIN_QHI] = e_high ? queue_exec[1] : queue_move[1];
      pe_oe_nxt[PIN_QHI] = 1'b1;
    end
    if (qt_en) begin
      pe_out_nxt[PIN_QLO] = e_high ? queue_exec[0] : queue_move[0];
      pe_oe_nxt[PIN_QLO] = 1'b1;
    end
    if (expanded_r) begin
      pe_out_nxt[PIN_BUS_E_CLOCK] = bus_e_clock;
      pe_oe_nxt[PIN_BUS_E_CLOCK] = 1'b1;
    end
    if (low_byte_strobe_n_en) begin
      pe_out_nxt[PIN_LOW_BYTE_STROBE_N] = ~(core_addr0 ^ byte_size_n);
      pe_oe_nxt[PIN_LOW_BYTE_STROBE_N] = 1'b1;
    end
    if (rw_en) begin
      pe_out_nxt[PIN_RW] = core_read;
      pe_oe_nxt[PIN_RW] = 1'b1;
    end
  end

  // Pins are registered so no decode glitch reaches the board
  always_ff @(posedge clk) begin
    if (!nrst) begin
      port_e_out <= 8'h00;
      port_e_oe <= 8'h00;
    end else begin
      port_e_out <= pe_out_nxt;
      port_e_oe <= pe_oe_nxt;
    end
  end

  // Undriven pins keep their pull-up, as after reset
  assign port_e_pullup = ~port_e_oe;

  // Tag sampled in special expanded mode as E falls
  always_ff @(posedge clk) begin
    if (!nrst) begin
      low_tag_input <= 1'b0;
    end else if (special_r && expanded_r && quarter_r == Q_LAST) begin
      low_tag_input <= pin_s2_r[PIN_LOW_BYTE_STROBE_N];
    end
  end

  // Reset pin pulled low on watchdog or clock monitor fault
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reset_pin_oe <= 1'b0;
    end else begin
      reset_pin_oe <= watchdog_timeout || clock_monitor_fail;
    end
  end
  assign reset_pin_out = 1'b0;
  assign pin_reset_n = rst_s2_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  rw_gate_a: assert property (
    !$past(rw_en) && !$past(dir_r[PIN_RW]) |-> !port_e_oe[PIN_RW])
    else $error("read/write pin driven while disabled");
  strobe_gate_a: assert property (
    !$past(low_byte_strobe_n_en) && !$past(dir_r[PIN_LOW_BYTE_STROBE_N]) |-> !port_e_oe[PIN_LOW_BYTE_STROBE_N])
    else $error("low strobe driven while disabled");
  dbe_ehigh_a: assert property (
    pe7_func == P7_DBE && !stretch_act_r && e_high
    |=> !port_e_out[PIN_DBE] && port_e_oe[PIN_DBE])
    else $error("drive enable not low in E high");
  dbe_stretch_a: assert property (
    pe7_func == P7_DBE && stretch_act_r &&
    !(quarter_r == Q_LAST && stretch_left_r == 2'h0)
    |=> port_e_out[PIN_DBE])
    else $error("drive enable early in stretch");
  dbe_reset_a: assert property (
    init_r && mode_s2_r[0] |=> !assign_r[BIT_BUS_DRIVE_CTRL_OFF])
    else $error("drive enable off after expanded reset");
  slow_duty_a: assert property (
    slow_cnt_r >= slow_div_r && !reg_wr |=> $changed(slow_divided_clock)
    ##1 (slow_cnt_r == 8'h01 || slow_div_r == 8'h00))
    else $error("slow clock toggle missed");
  dbe_over_cal_a: assert property (
    pe7_func == P7_DBE && assign_r[BIT_CALIB_OUT_EN]
    |=> port_e_out[PIN_DBE] == $past(bus_drive_enable_n))
    else $error("calibration overrode drive enable");
  cgm_gate_a: assert property (
    assign_r[BIT_QUEUE_TRACK_OUT_EN] && qt_en |=>
    port_e_out[PIN_QHI] == $past(e_high ? queue_exec[1] : queue_move[1]))
    else $error("test clock shown with queue tracking on");
  reset_drive_a: assert property (
    watchdog_timeout |=> reset_pin_oe && !reset_pin_out)
    else $error("reset pin not driven low");
  strobe_value_a: assert property (
    low_byte_strobe_n_en |=> port_e_out[PIN_LOW_BYTE_STROBE_N] == $past(~(core_addr0 ^ byte_size_n)))
    else $error("low strobe value wrong");

  stretch_c: cover property (stretch_act_r && pe7_func == P7_DBE
    && !bus_drive_enable_n);
  cal_c: cover property (pe7_func == P7_CAL ##1 $rose(port_e_out[PIN_DBE]));
  cgm_c: cover property (cgm_en ##1 port_e_oe[PIN_QHI]);
endmodule // port_e_bus_control_pin_mux

/* File: logic/pe_ctrl_pkg.sv */
package pe_ctrl_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] ADDR_ASSIGN = 3'h0;
  localparam logic [2:0] ADDR_DATA = 3'h1;
  localparam logic [2:0] ADDR_DIR = 3'h2;
  localparam logic [2:0] ADDR_SLOW_DIV = 3'h3;
  localparam logic [2:0] ADDR_STATUS = 3'h4;
  // Fields of port_e_assign_reg
  localparam int BIT_BUS_DRIVE_CTRL_OFF = 7;
  localparam int BIT_CLOCKGEN_TEST_EN = 6;
  localparam int BIT_QUEUE_TRACK_OUT_EN = 5;
  localparam int BIT_LOW_STROBE_FUNC_EN = 4;
  localparam int BIT_READ_WRITE_FUNC_EN = 3;
  localparam int BIT_CALIB_OUT_EN = 2;
  localparam int BIT_INV_ECLOCK_SEL = 1;
  // Drive control starts off until the mode straps are known
  localparam logic [7:0] ASSIGN_RESET = 8'h80;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] SLOW_DIV_RESET = 8'h00;
  // E clock is built from four clock quarters
  localparam int CLK_PERIOD_NS = 100;
  localparam int E_PERIOD_NS = 400;
  localparam int E_QUARTERS = E_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] Q_LAST = 2'(E_QUARTERS - 1);
  localparam logic [1:0] Q_HIGH_FIRST = 2'(E_QUARTERS / 2);
  // Port E bit positions
  localparam int PIN_RW = 2;
  localparam int PIN_LOW_BYTE_STROBE_N = 3;
  localparam int PIN_BUS_E_CLOCK = 4;
  localparam int PIN_QLO = 5;
  localparam int PIN_QHI = 6;
  localparam int PIN_DBE = 7;
  typedef enum logic [3:0] {
    P7_GPIO = 4'h1,
    P7_DBE = 4'h2,
    P7_INV_E = 4'h4,
    P7_CAL = 4'h8
  } pe7_func_t;
endpackage

/* File: verif/ext_bus_model.sv */
`timescale 1ns/10ps
module ext_bus_model (
  input wire logic clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  output logic [7:0] pin_level
);
  logic [7:0] float_r = 8'h55;
  // Floating pins wander so a stale level never passes for a drive
  always_ff @(posedge clk) begin
    float_r <= ~float_r;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pin_level[i] = pin_out[i];
      end else if (pin_pullup[i]) begin
        pin_level[i] = 1'b1;
      end else begin
        pin_level[i] = float_r[i];
      end
    end
  end
endmodule // ext_bus_model

/* File: verif/port_e_bus_control_pin_mux_tb.sv */
`timescale 1ns/10ps
module port_e_bus_control_pin_mux_tb;
  import pe_ctrl_pkg::*;
  logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, pe_in, pe_out, pe_oe, pe_pu;
  logic core_read = 0, a0 = 0, sz = 0, cg_out = 0, wdog = 0;
  logic tag, rst_out, rst_oe, pin_rst_n, p;
  logic [1:0] qm = 2'h0, qe = 2'h0;
  int err_count = 0, checks_done = 0, hi;
  always #50 clk = ~clk;
  port_e_bus_control_pin_mux dut (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mode_expanded_pin(1'b1), .mode_special_pin(1'b0),
    .ext_access(1'b0), .ext_stretch(2'h0), .core_read(core_read),
    .core_addr0(a0), .byte_size_n(sz), .queue_move(qm),
    .queue_exec(qe), .clockgen_test_out(cg_out),
    .watchdog_timeout(wdog), .clock_monitor_fail(1'b0),
    .port_e_in(pe_in), .port_e_out(pe_out), .port_e_oe(pe_oe),
    .port_e_pullup(pe_pu), .low_tag_input(tag),
    .reset_pin_in(~rst_oe), .reset_pin_out(rst_out),
    .reset_pin_oe(rst_oe), .pin_reset_n(pin_rst_n));
  ext_bus_model partner (.clk(clk), .pin_out(pe_out), .pin_oe(pe_oe),
    .pin_pullup(pe_pu), .pin_level(pe_in));
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    cyc(2);
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] exp, string nm);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata);
  endtask
  // Bit 7 must mirror bit 4 inverted; also counts E high cycles
  task automatic e_track(string nm);
    hi = 0;
    repeat (16) begin
      cyc(1);
      hi += int'(pe_out[4]);
      chk(nm, {7'h0, ~pe_out[4]}, {7'h0, pe_out[7]});
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    cyc(4);
    rd(ADDR_ASSIGN, 8'h00, "assign");
    rd(3'h5, 8'h00, "unmapped");
    chk("rw oe", 8'h00, {7'h0, pe_oe[2]});
    chk("rw pull", 8'h01, {7'h0, pe_pu[2]});
    chk("strb oe", 8'h00, {7'h0, pe_oe[3]});
    chk("dbe oe", 8'h01, {7'h0, pe_oe[7]});
    e_track("dbe");
    chk("e duty", 8'h08, 8'(hi));
    core_read <= 1'b1;
    wr(ADDR_ASSIGN, 8'h18);
    chk("rw out", 8'h01, {7'h0, pe_oe[2] & pe_out[2]});
    for (int i = 0; i < 4; i++) begin
      a0 <= i[0];
      sz <= i[1];
      cyc(3);
      chk("strobe", {7'h0, ~(i[0] ^ i[1])}, {7'h0, pe_out[3]});
    end
    wr(ADDR_ASSIGN, 8'h02);
    e_track("inv e");
    wr(ADDR_ASSIGN, 8'h84);
    // Divider at zero toggles every clock, the crystal rate
    hi = 0;
    repeat (16) begin
      p = pe_out[7];
      cyc(1);
      hi += int'(pe_out[7]);
      chk("cal toggle", {7'h0, ~p}, {7'h0, pe_out[7]});
    end
    chk("cal duty", 8'h08, 8'(hi));
    wr(ADDR_ASSIGN, 8'h04);
    e_track("dbe over cal");
    wr(ADDR_DATA, 8'h80);
    wr(ADDR_DIR, 8'h80);
    wr(ADDR_ASSIGN, 8'h80);
    chk("gpio7", 8'h03, {6'h0, pe_oe[7], pe_out[7]});
    cg_out <= 1'b1;
    wr(ADDR_ASSIGN, 8'hC0);
    chk("cgm hi", 8'h01, {7'h0, pe_out[6]});
    cg_out <= 1'b0;
    cyc(3);
    chk("cgm lo", 8'h00, {7'h0, pe_out[6]});
    qm <= 2'h1;
    qe <= 2'h2;
    wr(ADDR_ASSIGN, 8'h20);
    repeat (8) begin
      cyc(1);
      chk("queue", {6'h0, pe_out[4] ? qe : qm}, {6'h0, pe_out[6:5]});
    end
    wdog <= 1'b1;
    cyc(2);
    chk("rst oe", 8'h01, {7'h0, rst_oe});
    cyc(2);
    chk("rst in", 8'h00, {7'h0, pin_rst_n});
    wdog <= 1'b0;
    cyc(4);
    finish_test();
  end
endmodule // port_e_bus_control_pin_mux_tb
